//--- pkg/cpm_pkg.sv
// constants and types shared by the clock and power-mode controller
package cpm_pkg;
   // register byte offsets
   localparam logic [7:0] A_SRC     = 8'h00;
   localparam logic [7:0] A_SYNCTL  = 8'h04;
   localparam logic [7:0] A_SYNCFG  = 8'h08;
   localparam logic [7:0] A_SYNSTAT = 8'h0C;
   localparam logic [7:0] A_CPUDIV  = 8'h10;
   localparam logic [7:0] A_USBDIV  = 8'h14;
   localparam logic [7:0] A_USBSYN  = 8'h18;
   localparam logic [7:0] A_CLKOUT  = 8'h1C;
   localparam logic [7:0] A_PWRMODE = 8'h20;
   localparam logic [7:0] A_PWRSTAT = 8'h24;
   localparam logic [7:0] A_PGATE   = 8'h28;
   localparam logic [7:0] A_PDIV    = 8'h2C;
   localparam logic [7:0] A_MOSC    = 8'h30;

   // field positions
   localparam int EN_B       = 0;
   localparam int CONN_B     = 1;
   localparam int CFG_M_LSB  = 0;
   localparam int CFG_N_LSB  = 16;
   localparam int CKO_EN_B   = 4;

   // reset values
   localparam logic [7:0]  RST_PGATE  = 8'hFF;
   localparam logic [7:0]  RST_CPUDIV = 8'h00;
   localparam logic [3:0]  RST_USBDIV = 4'h0;
   localparam logic [7:0]  RST_PDIV_N = 8'h00;
   localparam logic [14:0] RST_MULT   = 15'h0000;
   localparam logic [15:0] RST_PDIV   = 16'h0000;

   localparam int NPER = 8;

   // timing, in oscillator cycles; FLASH_US in microseconds, IRC_MHZ in MHz
   localparam logic [12:0] WAKE_IRC_CYC  = 13'h0004;
   localparam logic [12:0] WAKE_MAIN_CYC = 13'h1000;
   localparam logic [12:0] WUT_CYC       = 13'h1000;
   localparam int          FLASH_US      = 100;
   localparam int          IRC_MHZ       = 4;
   localparam logic [12:0] FLASH_CYC     = 13'(FLASH_US * IRC_MHZ);

   typedef enum logic [1:0] {
      SRC_IRC   = 2'h0,
      SRC_MAIN  = 2'h1,
      SRC_RTC   = 2'h2,
      SRC_SYNTH = 2'h3
   } cpm_src_t;

   typedef enum logic [1:0] {
      MODE_SLEEP = 2'h0,
      MODE_DEEP  = 2'h1,
      MODE_PDOWN = 2'h2
   } cpm_mode_t;

   typedef enum logic [4:0] {
      ST_RUN   = 5'h01,
      ST_SLEEP = 5'h02,
      ST_DEEP  = 5'h04,
      ST_PDOWN = 5'h08,
      ST_WAKE  = 5'h10
   } cpm_state_t;

   // oscillator levels
   typedef struct packed {
      logic rtc;
      logic main;
      logic internal_rc_osc;
   } cpm_osc_t;

   // settings driven to the main synthesiser
   typedef struct packed {
      logic        enable;
      logic [7:0]  pdiv;
      logic [14:0] mult;
   } cpm_synth_t;
endpackage

//--- logic/cpm_top.sv
// clock source selection, synthesiser control and power-mode sequencing
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpm_top (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire cpm_pkg::cpm_osc_t      osc,
   input  wire logic                   synth_clk,
   input  wire logic                   synth_lock,
   input  wire logic                   usb_synth_clk,
   input  wire logic                   usb_synth_lock,
   input  wire logic                   sleep_req,
   input  wire logic                   irq_any,
   input  wire logic                   wake_irq,
   output cpm_pkg::cpm_synth_t         synth,
   output logic                        usb_synth_enable,
   output logic                        cpu_clock,
   output logic                        usb_clock,
   output logic [cpm_pkg::NPER-1:0]    per_clk_en,
   output logic                        clkout,
   output logic                        main_osc_run,
   output logic                        irc_power,
   output logic                        irc_out_en,
   output logic                        rtc_osc_run,
   output logic                        flash_power,
   output logic                        flash_ready
);
   // software state
   logic [1:0]                src;
   logic                      syn_en;
   logic                      syn_conn;
   logic [7:0]                pdiv_n;
   logic [14:0]               mult_m;
   logic [7:0]                cpudiv;
   logic [3:0]                usbdiv;
   logic                      usb_en;
   logic                      usb_conn;
   logic [2:0]                ck_sel;
   logic                      ck_en;
   logic [1:0]                pmode;
   logic [7:0]                pgate;
   logic [15:0]               pdiv;
   logic                      mosc_en;
   // hardware state
   cpm_pkg::cpm_state_t       st;
   cpm_pkg::cpm_state_t       next_st;
   logic                      mosc_ready;
   logic [12:0]               wut;
   logic [12:0]               wcnt;
   logic [12:0]               fcnt;
   logic                      wake_main;
   logic [1:0]                cur;
   logic                      park;
   logic [3:0]                lvl_q;
   logic                      base_q;
   logic [7:0]                div_cnt;
   logic                      cpu_q;
   logic                      core_on;
   logic [3:0]                usb_cnt;
   logic                      usb_q;
   logic                      synth_q;

   // bus decode
   wire wr        = psel & penable & pwrite;
   wire hit_src   = paddr == cpm_pkg::A_SRC;
   wire hit_synct = paddr == cpm_pkg::A_SYNCTL;
   wire hit_syncf = paddr == cpm_pkg::A_SYNCFG;
   wire hit_synst = paddr == cpm_pkg::A_SYNSTAT;
   wire hit_cdiv  = paddr == cpm_pkg::A_CPUDIV;
   wire hit_udiv  = paddr == cpm_pkg::A_USBDIV;
   wire hit_usyn  = paddr == cpm_pkg::A_USBSYN;
   wire hit_cko   = paddr == cpm_pkg::A_CLKOUT;
   wire hit_pmode = paddr == cpm_pkg::A_PWRMODE;
   wire hit_pstat = paddr == cpm_pkg::A_PWRSTAT;
   wire hit_pgate = paddr == cpm_pkg::A_PGATE;
   wire hit_pdiv  = paddr == cpm_pkg::A_PDIV;
   wire hit_mosc  = paddr == cpm_pkg::A_MOSC;
   wire hit = hit_src | hit_synct | hit_syncf | hit_synst | hit_cdiv | hit_udiv
            | hit_usyn | hit_cko | hit_pmode | hit_pstat | hit_pgate | hit_pdiv
            | hit_mosc;

   // state decode
   wire in_run   = st == cpm_pkg::ST_RUN;
   wire in_sleep = st == cpm_pkg::ST_SLEEP;
   wire in_deep  = st == cpm_pkg::ST_DEEP;
   wire in_pdown = st == cpm_pkg::ST_PDOWN;
   wire in_wake  = st == cpm_pkg::ST_WAKE;
   wire clk_on   = in_run | in_sleep;
   wire enter_low = in_run & sleep_req & (pmode == cpm_pkg::MODE_DEEP
                  | pmode == cpm_pkg::MODE_PDOWN);

   // synthesiser use only once enabled and locked
   wire syn_conn_eff = syn_en & syn_conn & synth_lock;
   wire usb_conn_eff = usb_en & usb_conn & usb_synth_lock;

   // edge detection of sampled clock levels
   wire [3:0] lvls   = {synth_clk, osc.rtc, osc.main, osc.internal_rc_osc};
   wire [3:0] rises  = lvls & ~lvl_q;
   wire       wake_edge = wake_main ? rises[1] : rises[0];
   wire [12:0] wlim  = wake_main ? cpm_pkg::WAKE_MAIN_CYC : cpm_pkg::WAKE_IRC_CYC;

   // wanted cpu source; crystal held off until judged stable
   wire [1:0] want = syn_conn_eff ? cpm_pkg::SRC_SYNTH
                   : (src == cpm_pkg::SRC_MAIN && mosc_ready) ? cpm_pkg::SRC_MAIN
                   : (src == cpm_pkg::SRC_RTC) ? cpm_pkg::SRC_RTC
                   : cpm_pkg::SRC_IRC;
   wire want_fall = lvl_q[want] & ~lvls[want];
   wire base_lvl  = park ? 1'b0 : lvls[cur];
   wire base_rise = base_lvl & ~base_q;

   // register read mux
   wire [31:0] rd_val =
        hit_src   ? {30'h0000_0000, src}
      : hit_synct ? {30'h0000_0000, syn_conn, syn_en}
      : hit_syncf ? {8'h00, pdiv_n, 1'h0, mult_m}
      : hit_synst ? {28'h000_0000, flash_ready, mosc_ready, syn_conn_eff, synth_lock}
      : hit_cdiv  ? {24'h00_0000, cpudiv}
      : hit_udiv  ? {28'h000_0000, usbdiv}
      : hit_usyn  ? {29'h0000_0000, usb_synth_lock, usb_conn, usb_en}
      : hit_cko   ? {27'h000_0000, ck_en, 1'h0, ck_sel}
      : hit_pmode ? {30'h0000_0000, pmode}
      : hit_pstat ? {27'h000_0000, st}
      : hit_pgate ? {24'h00_0000, pgate}
      : hit_pdiv  ? {16'h0000, pdiv}
      : hit_mosc  ? {30'h0000_0000, mosc_ready, mosc_en}
      : 32'h0000_0000;

   // zero-wait slave, error on unmapped offsets
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= rd_val;
      end
   end

   // software registers; low-power entry overrides a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src      <= cpm_pkg::SRC_IRC;
         syn_en   <= 1'b0;
         syn_conn <= 1'b0;
         pdiv_n   <= cpm_pkg::RST_PDIV_N;
         mult_m   <= cpm_pkg::RST_MULT;
         cpudiv   <= cpm_pkg::RST_CPUDIV;
         usbdiv   <= cpm_pkg::RST_USBDIV;
         usb_en   <= 1'b0;
         usb_conn <= 1'b0;
         ck_sel   <= 3'h0;
         ck_en    <= 1'b0;
         pmode    <= cpm_pkg::MODE_SLEEP;
         pgate    <= cpm_pkg::RST_PGATE;
         pdiv     <= cpm_pkg::RST_PDIV;
         mosc_en  <= 1'b0;
      end else if (enter_low) begin
         syn_en   <= 1'b0;
         syn_conn <= 1'b0;
         cpudiv   <= 8'h00;
         usbdiv   <= 4'h0;
      end else if (wr) begin
         if (hit_src) begin
            src <= pwdata[1:0];
         end
         if (hit_synct) begin
            syn_en   <= pwdata[cpm_pkg::EN_B];
            syn_conn <= pwdata[cpm_pkg::CONN_B];
         end
         if (hit_syncf) begin
            pdiv_n <= pwdata[cpm_pkg::CFG_N_LSB +: 8];
            mult_m <= pwdata[cpm_pkg::CFG_M_LSB +: 15];
         end
         if (hit_cdiv) begin
            cpudiv <= pwdata[7:0];
         end
         if (hit_udiv) begin
            usbdiv <= pwdata[3:0];
         end
         if (hit_usyn) begin
            usb_en   <= pwdata[cpm_pkg::EN_B];
            usb_conn <= pwdata[cpm_pkg::CONN_B];
         end
         if (hit_cko) begin
            ck_sel <= pwdata[2:0];
            ck_en  <= pwdata[cpm_pkg::CKO_EN_B];
         end
         if (hit_pmode) begin
            pmode <= pwdata[1:0];
         end
         if (hit_pgate) begin
            pgate <= pwdata[7:0];
         end
         if (hit_pdiv) begin
            pdiv <= pwdata[15:0];
         end
         if (hit_mosc) begin
            mosc_en <= pwdata[cpm_pkg::EN_B];
         end
      end
   end

   // power-mode sequencer
   always_comb begin
      next_st = st;
      case (st)
         cpm_pkg::ST_RUN: begin
            if (sleep_req) begin
               if (pmode == cpm_pkg::MODE_DEEP) begin
                  next_st = cpm_pkg::ST_DEEP;
               end else if (pmode == cpm_pkg::MODE_PDOWN) begin
                  next_st = cpm_pkg::ST_PDOWN;
               end else begin
                  next_st = cpm_pkg::ST_SLEEP;
               end
            end
         end
         cpm_pkg::ST_SLEEP: if (irq_any) next_st = cpm_pkg::ST_RUN;
         cpm_pkg::ST_DEEP,
         cpm_pkg::ST_PDOWN: if (wake_irq) next_st = cpm_pkg::ST_WAKE;
         cpm_pkg::ST_WAKE: begin
            if (wake_edge && wcnt == wlim - 13'h0001) next_st = cpm_pkg::ST_RUN;
         end
         default: next_st = cpm_pkg::ST_RUN;
      endcase
   end

   // state, wake latency and prior source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st        <= cpm_pkg::ST_RUN;
         wcnt      <= 13'h0000;
         wake_main <= 1'b0;
      end else begin
         st <= next_st;
         if (enter_low) begin
            wake_main <= src == cpm_pkg::SRC_MAIN && mosc_ready;
         end
         if (!in_wake) begin
            wcnt <= 13'h0000;
         end else if (wake_edge) begin
            wcnt <= wcnt + 13'h0001;
         end
      end
   end

   // crystal wake-up timer, restarted by power-down or disable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wut        <= 13'h0000;
         mosc_ready <= 1'b0;
      end else if (!mosc_en || in_pdown) begin
         wut        <= 13'h0000;
         mosc_ready <= 1'b0;
      end else if (main_osc_run && !mosc_ready && rises[1]) begin
         wut        <= wut + 13'h0001;
         mosc_ready <= wut == cpm_pkg::WUT_CYC - 13'h0001;
      end
   end

   // flash wake timer on rc cycles after power-down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fcnt        <= 13'h0000;
         flash_ready <= 1'b1;
      end else if (in_pdown) begin
         fcnt        <= 13'h0000;
         flash_ready <= 1'b0;
      end else if (!flash_ready && rises[0]) begin
         fcnt        <= fcnt + 13'h0001;
         flash_ready <= fcnt == cpm_pkg::FLASH_CYC - 13'h0001;
      end
   end

   // glitch-free switch: park low, adopt new source at its falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur    <= cpm_pkg::SRC_IRC;
         park   <= 1'b0;
         lvl_q  <= 4'h0;
         base_q <= 1'b0;
      end else begin
         lvl_q  <= lvls;
         base_q <= base_lvl;
         if (!park && want != cur && !lvls[cur]) begin
            park <= 1'b1;
         end else if (park && want_fall) begin
            park <= 1'b0;
            cur  <= want;
         end
      end
   end

   // cpu divider and core gate that only closes while the clock is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 8'h00;
         cpu_q   <= 1'b0;
         core_on <= 1'b1;
      end else begin
         if (base_rise) begin
            if (div_cnt >= cpudiv) begin
               div_cnt <= 8'h00;
               cpu_q   <= ~cpu_q;
            end else begin
               div_cnt <= div_cnt + 8'h01;
            end
         end
         if (!cpu_q) begin
            core_on <= in_run;
         end
      end
   end
   assign cpu_clock = cpu_q & core_on;

   // usb fallback divider from the main synthesiser output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_cnt <= 4'h0;
         usb_q   <= 1'b0;
         synth_q <= 1'b0;
      end else begin
         synth_q <= synth_clk;
         if (synth_clk && !synth_q) begin
            if (usb_cnt >= usbdiv) begin
               usb_cnt <= 4'h0;
               usb_q   <= ~usb_q;
            end else begin
               usb_cnt <= usb_cnt + 4'h1;
            end
         end
      end
   end
   assign usb_clock = (usb_conn_eff ? usb_synth_clk : usb_q) & clk_on;

   // per-peripheral divider (1,2,4,8) and gate, running through sleep
   for (genvar gi = 0; gi < cpm_pkg::NPER; gi++) begin : g_per
      logic [2:0] cnt;
      wire  [2:0] lim = 3'((1 << pdiv[2*gi +: 2]) - 1);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt <= 3'h0;
         end else if (base_rise) begin
            cnt <= (cnt >= lim) ? 3'h0 : cnt + 3'h1;
         end
      end
      assign per_clk_en[gi] = pgate[gi] & clk_on & base_rise & (cnt >= lim);
   end

   // clock output pin, registered
   wire ck_mux = (ck_sel == 3'h0) ? cpu_clock
               : (ck_sel == 3'h1) ? osc.internal_rc_osc
               : (ck_sel == 3'h2) ? osc.main
               : (ck_sel == 3'h3) ? osc.rtc
               : (ck_sel == 3'h4) ? usb_clock
               : 1'b0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clkout <= 1'b0;
      end else begin
         clkout <= ck_en & ck_mux;
      end
   end

   // analogue controls
   assign synth.enable     = syn_en;
   assign synth.pdiv       = pdiv_n;
   assign synth.mult       = mult_m;
   assign usb_synth_enable = usb_en;
   assign main_osc_run     = mosc_en & ~in_deep & ~in_pdown;
   assign irc_power        = ~in_pdown;
   assign irc_out_en       = ~in_deep & ~in_pdown;
   assign rtc_osc_run      = 1'b1;
   assign flash_power      = ~in_pdown;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_main_held_off: assert property (!mosc_ready && !park |-> cur != cpm_pkg::SRC_MAIN)
      else $error("crystal used before stable");
   a_synth_drop: assert property (enter_low |=> !syn_en && !syn_conn && !synth.enable)
      else $error("synth not dropped on deep entry");
   a_div_cleared: assert property ($rose(in_deep) |-> cpudiv == 8'h00 && usbdiv == 4'h0)
      else $error("dividers not cleared");
   a_sleep_core: assert property (in_sleep && !cpu_q |=> !cpu_clock)
      else $error("core clock runs in sleep");
   a_deep_quiet: assert property (in_deep |-> per_clk_en == '0 && !usb_clock && !main_osc_run)
      else $error("clocks run in deep-sleep");
   a_deep_power: assert property (in_deep |-> flash_power && irc_power && !irc_out_en)
      else $error("deep-sleep power wrong");
   a_wake_hold: assert property (in_wake && !wake_main && wcnt < 13'h0003 |=> in_wake)
      else $error("wake left early");
   a_deep_exit: assert property (in_deep && !wake_irq |=> in_deep)
      else $error("deep-sleep left without wake");
   a_synth_lock: assert property ($changed(cur) && cur == cpm_pkg::SRC_SYNTH |-> $past(syn_conn_eff))
      else $error("synth connected without lock");
   a_park_low: assert property (park |-> !base_lvl && !base_q)
      else $error("parked clock not low");
   a_flash_block: assert property (in_pdown |=> !flash_ready)
      else $error("flash ready in power-down");

   c_sleep_wake: cover property (in_sleep ##1 in_run);
   c_deep_wake: cover property (in_deep ##1 in_wake);
   c_pdown_flash: cover property (in_wake && !flash_ready);
   c_switch: cover property ($fell(park));
endmodule
`default_nettype wire

//--- verification/tb_cpm_top.sv
// self-checking bench for the clock and power-mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_cpm_top;
   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [7:0]           paddr = 8'h0;
   logic [31:0]          pwdata = 32'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   cpm_pkg::cpm_osc_t    osc = '0;
   logic                 synth_clk = 1'b0;
   logic                 synth_lock = 1'b0;
   logic                 usb_synth_clk = 1'b0;
   logic                 usb_synth_lock = 1'b0;
   logic                 sleep_req = 1'b0;
   logic                 irq_any = 1'b0;
   logic                 wake_irq = 1'b0;
   cpm_pkg::cpm_synth_t  synth;
   logic                 usb_synth_enable;
   logic                 cpu_clock;
   logic                 usb_clock;
   logic [7:0]           per_clk_en;
   logic                 clkout;
   logic                 main_osc_run;
   logic                 irc_power;
   logic                 irc_out_en;
   logic                 rtc_osc_run;
   logic                 flash_power;
   logic                 flash_ready;
   logic [1:0]           cnt = 2'h0;
   logic [31:0]          rdv;
   logic                 err;
   logic [31:0]          rv;
   integer               seed = 32'h3ac4_d701;
   int                   fails = 0;
   int                   checks_done = 0;
   int                   n_cpu = 0;
   int                   n_ck = 0;
   int                   n_per = 0;
   int                   a;
   int                   b;
   int                   k;

   cpm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc(osc), .synth_clk(synth_clk), .synth_lock(synth_lock),
      .usb_synth_clk(usb_synth_clk), .usb_synth_lock(usb_synth_lock),
      .sleep_req(sleep_req), .irq_any(irq_any), .wake_irq(wake_irq), .synth(synth),
      .usb_synth_enable(usb_synth_enable), .cpu_clock(cpu_clock), .usb_clock(usb_clock),
      .per_clk_en(per_clk_en), .clkout(clkout), .main_osc_run(main_osc_run),
      .irc_power(irc_power), .irc_out_en(irc_out_en), .rtc_osc_run(rtc_osc_run),
      .flash_power(flash_power), .flash_ready(flash_ready));

   // 50 mhz bus clock
   always #10 pclk = ~pclk;

   // oscillator levels, irc at a quarter of pclk, rtc random
   always @(posedge pclk) begin
      cnt <= cnt + 2'h1;
      osc.internal_rc_osc <= cnt[1];
      osc.main <= ~osc.main;
      osc.rtc <= 1'($random(seed));
      synth_clk <= ~synth_clk;
      synth_lock <= synth.enable; // lock follows enable one cycle later
      usb_synth_clk <= cnt[0];
      usb_synth_lock <= cnt[1];
      n_cpu <= n_cpu + int'(cpu_clock === 1'b1);
      n_ck <= n_ck + int'(clkout === 1'b1);
      n_per <= n_per + int'(per_clk_en !== 8'h0);
   end

   task automatic complete_run;
      $display("checks %0d, errors %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fails++;
         complete_run();
      end
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      `CHK(rdv, e)
   endtask

   // request a power mode with a one-cycle pulse
   task automatic enter(input logic [1:0] m);
      apb(1'b1, cpm_pkg::A_PWRMODE, {30'h0, m});
      @(posedge pclk);
      sleep_req <= 1'b1;
      @(posedge pclk);
      sleep_req <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic pulse_wake;
      @(posedge pclk);
      wake_irq <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
   endtask

   function automatic logic [31:0] st(input cpm_pkg::cpm_state_t s);
      st = {27'h0, s};
   endfunction

   function automatic logic [31:0] cfg(input logic [7:0] n, input logic [14:0] m);
      cfg = {8'h0, n, 1'b0, m};
   endfunction

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // reset state
      `CHK(synth, cpm_pkg::cpm_synth_t'(0))
      `CHK(usb_synth_enable, 1'b0)
      rd(cpm_pkg::A_SRC, 32'h0);
      rd(cpm_pkg::A_PGATE, {24'h0, cpm_pkg::RST_PGATE});
      rd(cpm_pkg::A_PWRSTAT, st(cpm_pkg::ST_RUN));
      rd(8'hFC, 32'h0);
      `CHK(err, 1'b1)
      a = n_cpu;
      repeat (40) @(posedge pclk);
      `CHK(n_cpu != a, 1'b1)
      // divider bounds then random values
      for (int i = 0; i < 6; i++) begin
         rv = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : $random(seed);
         apb(1'b1, cpm_pkg::A_SYNCFG, rv);
         rd(cpm_pkg::A_SYNCFG, cfg(rv[23:16], rv[14:0]));
         apb(1'b1, cpm_pkg::A_PDIV, rv);
         rd(cpm_pkg::A_PDIV, {16'h0, rv[15:0]});
      end
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, cpm_pkg::A_SRC, s);
         rd(cpm_pkg::A_SRC, s);
      end
      apb(1'b1, cpm_pkg::A_SRC, 32'h0);
      // each clock output selection 0 to 4 toggles the pin
      for (int s = 0; s < 5; s++) begin
         apb(1'b1, cpm_pkg::A_CLKOUT, 32'h10 | s);
         a = n_ck;
         repeat (60) @(posedge pclk);
         `CHK(n_ck != a, 1'b1)
      end
      apb(1'b1, cpm_pkg::A_CLKOUT, 32'h0);
      repeat (4) @(posedge pclk);
      a = n_ck;
      repeat (20) @(posedge pclk);
      `CHK(n_ck == a, 1'b1)
      // deep-sleep entry clears synth and dividers
      apb(1'b1, cpm_pkg::A_PGATE, 32'hFF);
      apb(1'b1, cpm_pkg::A_SYNCTL, 32'h1);
      @(posedge pclk);
      `CHK(synth.enable, 1'b1)
      rv = $random(seed);
      apb(1'b1, cpm_pkg::A_CPUDIV, rv | 32'h1);
      apb(1'b1, cpm_pkg::A_USBDIV, rv | 32'h1);
      enter(2'h1);
      rd(cpm_pkg::A_PWRSTAT, st(cpm_pkg::ST_DEEP));
      `CHK({main_osc_run, irc_out_en, irc_power, rtc_osc_run}, 4'h3)
      `CHK(flash_power, 1'b1)
      `CHK(synth.enable, 1'b0)
      rd(cpm_pkg::A_SYNCTL, 32'h0);
      rd(cpm_pkg::A_CPUDIV, 32'h0);
      rd(cpm_pkg::A_USBDIV, 32'h0);
      a = n_per;
      irq_any <= 1'b1;
      repeat (20) @(posedge pclk);
      irq_any <= 1'b0;
      `CHK(n_per == a, 1'b1)
      rd(cpm_pkg::A_PWRSTAT, st(cpm_pkg::ST_DEEP));
      pulse_wake();
      rd(cpm_pkg::A_PWRSTAT, st(cpm_pkg::ST_WAKE));
      repeat (24) @(posedge pclk);
      rd(cpm_pkg::A_PWRSTAT, st(cpm_pkg::ST_RUN));
      // reprogram after wake; m 25, n 1 gives 300 mhz from a 12 mhz crystal
      apb(1'b1, cpm_pkg::A_CPUDIV, 32'h0);
      apb(1'b1, cpm_pkg::A_SYNCFG, cfg(8'h00, 15'h0018));
      apb(1'b1, cpm_pkg::A_SYNCTL, 32'h1);
      rd(cpm_pkg::A_SYNSTAT, 32'h9);
      apb(1'b1, cpm_pkg::A_SYNCTL, 32'h3);
      rd(cpm_pkg::A_SYNSTAT, 32'hB);
      // sleep stops only the core clock
      enter(2'h0);
      rd(cpm_pkg::A_PWRSTAT, st(cpm_pkg::ST_SLEEP));
      // let the core gate close before counting
      repeat (8) @(posedge pclk);
      a = n_cpu;
      b = n_per;
      repeat (40) @(posedge pclk);
      `CHK(n_cpu == a, 1'b1)
      `CHK(n_per != b, 1'b1)
      irq_any <= 1'b1;
      repeat (2) @(posedge pclk);
      irq_any <= 1'b0;
      repeat (30) @(posedge pclk);
      rd(cpm_pkg::A_PWRSTAT, st(cpm_pkg::ST_RUN));
      // power-down drops synth and flash, flash timer on wake
      apb(1'b1, cpm_pkg::A_SYNCTL, 32'h1);
      enter(2'h2);
      @(posedge pclk);
      `CHK(synth.enable, 1'b0)
      `CHK(flash_ready, 1'b0)
      pulse_wake();
      repeat (800) @(posedge pclk);
      `CHK(flash_ready, 1'b0)
      k = 0;
      while (flash_ready !== 1'b1 && k < 2500) begin
         @(posedge pclk);
         k++;
      end
      `CHK(flash_ready, 1'b1)
      if (k == 2500)
         complete_run();
      // crystal held off until the wake-up timer expires
      apb(1'b1, cpm_pkg::A_MOSC, 32'h1);
      rd(cpm_pkg::A_MOSC, 32'h1);
      repeat (8400) @(posedge pclk);
      rd(cpm_pkg::A_MOSC, 32'h3);
      complete_run();
   end
endmodule
`default_nettype wire
